// ==== mscap_top.sv ====
/*
  mscap_top: interrupt message and board code capability registers of one
  switch port, reached over APB, with a message write sequencer.
  Assumes: single clock; upstream transmitter routes every write to the root;
  software programs an address that routes upstream.
*/
// Design decision made here: the APB register port.
// Overview of operation
// RULE1: interrupt header code reads 0x5
// RULE2: interrupt next link defaults zero
// RULE3: bit 16 enables messages, resets zero
// RULE4: requested count reads zero, read-only
// RULE5: granted count stored, always one message
// RULE6: bit 23 reads one, wide address
// RULE7: low address bits 31:2, 1:0 zero
// RULE8: non-zero upper address gives 64-bit write
// RULE9: zero upper address gives 32-bit write
// RULE10: all messages forwarded out upstream port
// RULE11: software programs address routing upstream
// RULE12: payload 16 bits, upper bits zero
// RULE13: board header code reads 0xD
// RULE14: board next link lockable, upper zero
// RULE15: board vendor code lockable, reset zero
// RULE16: board model code lockable, reset zero
// RULE17: write emitted only while enabled
// RULE18: lockable fields ignore writes when locked
`timescale 1ns/100ps

module mscap_top
  import mscap_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // interrupt request from port logic
  input  wire logic        irq_req_i,
  // upstream memory write
  output logic             wr_valid_o,
  output logic             wr_wide_o,
  output logic [63:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  input  wire logic        wr_accept_i,
  // lock state and interrupt
  output logic             locked_o,
  output logic             irq_o
);

  // ==========================================================================
  // storage
  // ==========================================================================
  logic        enable_r;
  logic [2:0]  granted_r;
  logic [7:0]  int_link_r;
  logic [29:0] addr_lo_r;
  logic [31:0] addr_hi_r;
  logic [15:0] payload_r;
  logic [7:0]  brd_link_r;
  logic [15:0] vendor_r;
  logic [15:0] model_r;
  logic        lock_r;
  logic [MSCAP_EVT_W-1:0] stat_r;
  logic [MSCAP_EVT_W-1:0] mask_r;
  logic        sent_w;
  logic        dropped_w;

  mscap_cfg_if cfg_if ();

  // ==========================================================================
  // bus decode
  // ==========================================================================
  logic        acc_w;
  logic        wr_w;
  logic        rd_w;
  logic        hit_int_w;
  logic        hit_lo_w;
  logic        hit_hi_w;
  logic        hit_pay_w;
  logic        hit_bhdr_w;
  logic        hit_bcode_w;
  logic        hit_ctrl_w;
  logic        hit_stat_w;
  logic        hit_mask_w;
  logic        mapped_w;
  logic        lock_wr_ok_w;
  logic [31:0] rdata_w;
  logic [MSCAP_EVT_W-1:0] evt_w;

  // transfer strobes, one wait state
  assign acc_w       = psel_i && penable_i;
  assign wr_w        = acc_w && pwrite_i;
  assign rd_w        = acc_w && !pwrite_i;
  assign hit_int_w   = (paddr_i == MSCAP_OFF_INT_HDR);
  assign hit_lo_w    = (paddr_i == MSCAP_OFF_ADDR_LO);
  assign hit_hi_w    = (paddr_i == MSCAP_OFF_ADDR_HI);
  assign hit_pay_w   = (paddr_i == MSCAP_OFF_PAYLOAD);
  assign hit_bhdr_w  = (paddr_i == MSCAP_OFF_BRD_HDR);
  assign hit_bcode_w = (paddr_i == MSCAP_OFF_BRD_CODES);
  assign hit_ctrl_w  = (paddr_i == MSCAP_OFF_CTRL);
  assign hit_stat_w  = (paddr_i == MSCAP_OFF_IRQ_STAT);
  assign hit_mask_w  = (paddr_i == MSCAP_OFF_IRQ_MASK);
  assign mapped_w    = hit_int_w | hit_lo_w | hit_hi_w | hit_pay_w | hit_bhdr_w
                     | hit_bcode_w | hit_ctrl_w | hit_stat_w | hit_mask_w;
  assign lock_wr_ok_w = wr_w && !lock_r;                     // [RULE18]
  assign evt_w       = {dropped_w, sent_w};

  // read data mux, constant fields read back fixed values
  assign rdata_w =
      hit_int_w   ? {8'h00, MSCAP_WIDE_CAPABLE, granted_r, MSCAP_REQ_COUNT, enable_r,
                     int_link_r, MSCAP_INT_CAP_CODE} :       // [RULE1] [RULE4] [RULE6]
      hit_lo_w    ? {addr_lo_r, MSCAP_ZERO2} :               // [RULE7]
      hit_hi_w    ? addr_hi_r :
      hit_pay_w   ? {MSCAP_ZERO16, payload_r} :              // [RULE12]
      hit_bhdr_w  ? {MSCAP_ZERO16, brd_link_r, MSCAP_BRD_CAP_CODE} : // [RULE13] [RULE14]
      hit_bcode_w ? {model_r, vendor_r} :                    // [RULE15] [RULE16]
      hit_ctrl_w  ? {31'h0, lock_r} :
      hit_stat_w  ? {30'h0, stat_r} :
      hit_mask_w  ? {30'h0, mask_r} : MSCAP_ZERO32;

  // ==========================================================================
  // apb answer
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      // answer registered: ready one cycle into the access phase
      pready_o  <= acc_w && !pready_o;
      pslverr_o <= acc_w && !pready_o && !mapped_w;
      if (rd_w && !pready_o)
        prdata_o <= rdata_w;
    end
  end

  logic commit_w;
  assign commit_w = wr_w && pready_o;

  // ==========================================================================
  // interrupt capability registers
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      enable_r   <= 1'b0;
      granted_r  <= MSCAP_GRANT_RST;
      int_link_r <= MSCAP_NEXT_LINK_RST;
      addr_lo_r  <= 30'h0;
      addr_hi_r  <= 32'h0;
      payload_r  <= 16'h0;
    end
    else if (commit_w)
    begin
      if (hit_int_w)
      begin
        enable_r  <= pwdata_i[16];                           // [RULE3]
        granted_r <= pwdata_i[22:20];                        // [RULE5]
        if (!lock_r)
          int_link_r <= pwdata_i[15:8];                      // [RULE2] [RULE18]
      end
      if (hit_lo_w)
        addr_lo_r <= pwdata_i[31:2];                         // [RULE7]
      if (hit_hi_w)
        addr_hi_r <= pwdata_i;
      if (hit_pay_w)
        payload_r <= pwdata_i[15:0];                         // [RULE12]
    end
  end

  // ==========================================================================
  // board code registers, lockable
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      brd_link_r <= MSCAP_NEXT_LINK_RST;
      vendor_r   <= 16'h0;
      model_r    <= 16'h0;
      lock_r     <= 1'b0;
    end
    else if (commit_w)
    begin
      if (hit_bhdr_w && lock_wr_ok_w)
        brd_link_r <= pwdata_i[15:8];                        // [RULE14] [RULE18]
      if (hit_bcode_w && lock_wr_ok_w)
      begin
        vendor_r <= pwdata_i[15:0];                          // [RULE15]
        model_r  <= pwdata_i[31:16];                         // [RULE16]
      end
      if (hit_ctrl_w && pwdata_i[0])
        lock_r <= 1'b1;                                      // lock holds until reset
    end
  end

  // ==========================================================================
  // event status, mask and interrupt line
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat_r   <= '0;
      mask_r   <= '0;
      irq_o    <= 1'b0;
      locked_o <= 1'b0;
    end
    else
    begin
      // a new event beats the read clear
      if (rd_w && pready_o && hit_stat_w)
        stat_r <= evt_w;
      else
        stat_r <= stat_r | evt_w;
      if (commit_w && hit_mask_w)
        mask_r <= pwdata_i[MSCAP_EVT_W-1:0];
      irq_o    <= |(stat_r & mask_r);
      locked_o <= lock_r;
    end
  end

  // settings to the sequencer
  assign cfg_if.msg_enable = enable_r;
  assign cfg_if.addr_low   = addr_lo_r;
  assign cfg_if.addr_high  = addr_hi_r;
  assign cfg_if.payload    = payload_r;

  // ==========================================================================
  // message write sequencer
  // ==========================================================================
  mscap_msg_seq u_seq (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .cfg         (cfg_if.seq),
    .irq_req_i   (irq_req_i),
    .wr_valid_o  (wr_valid_o),
    .wr_wide_o   (wr_wide_o),
    .wr_addr_o   (wr_addr_o),
    .wr_data_o   (wr_data_o),
    .wr_accept_i (wr_accept_i),
    .sent_o      (sent_w),
    .dropped_o   (dropped_w)
  );

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_int_hdr_const;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_w && !pready_o && hit_int_w) |=> (prdata_o[7:0] == MSCAP_INT_CAP_CODE && prdata_o[19:17] == 3'h0
                                            && prdata_o[23] && prdata_o[31:24] == 8'h00);
  endproperty
  a_int_hdr_const: assert property (p_int_hdr_const) else $error("interrupt header constants wrong"); // [RULE1]

  property p_enable_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      (commit_w && hit_int_w) |=> (enable_r == $past(pwdata_i[16]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not stored"); // [RULE3]

  property p_addr_lo_low_bits;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_w && !pready_o && hit_lo_w) |=> (prdata_o[1:0] == 2'h0);
  endproperty
  a_addr_lo_low_bits: assert property (p_addr_lo_low_bits) else $error("low address bits not zero"); // [RULE7]

  property p_payload_upper;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_w && !pready_o && hit_pay_w) |=> (prdata_o[31:16] == 16'h0);
  endproperty
  a_payload_upper: assert property (p_payload_upper) else $error("payload upper bits not zero"); // [RULE12]

  property p_brd_hdr_const;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_w && !pready_o && hit_bhdr_w) |=> (prdata_o[7:0] == MSCAP_BRD_CAP_CODE && prdata_o[31:16] == 16'h0);
  endproperty
  a_brd_hdr_const: assert property (p_brd_hdr_const) else $error("board header constants wrong"); // [RULE13]

  property p_locked_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      lock_r |=> ($stable(vendor_r) && $stable(model_r) && $stable(brd_link_r));
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked field changed"); // [RULE18]

  property p_codes_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      (commit_w && hit_bcode_w && !lock_r) |=> ({model_r, vendor_r} == $past(pwdata_i));
  endproperty
  a_codes_write: assert property (p_codes_write) else $error("board codes not stored"); // [RULE15]

  property p_payload_out;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(wr_valid_o) |-> (wr_data_o[15:0] == payload_r && wr_addr_o[1:0] == 2'h0);
  endproperty
  a_payload_out: assert property (p_payload_out) else $error("write carries wrong payload"); // [RULE12]

endmodule : mscap_top

// ==== mscap_pkg.sv ====
/*
  mscap_pkg: register map, field layout and reset values of the interrupt
  message and board code capability block.
  Assumes: a 32-bit APB register bus, byte addresses as printed.
*/
package mscap_pkg;

  // ==========================================================================
  // register byte addresses
  // ==========================================================================
  localparam logic [11:0] MSCAP_OFF_INT_HDR    = 12'h0d0;
  localparam logic [11:0] MSCAP_OFF_ADDR_LO    = 12'h0d4;
  localparam logic [11:0] MSCAP_OFF_ADDR_HI    = 12'h0d8;
  localparam logic [11:0] MSCAP_OFF_PAYLOAD    = 12'h0dc;
  localparam logic [11:0] MSCAP_OFF_BRD_HDR    = 12'h0f0;
  localparam logic [11:0] MSCAP_OFF_BRD_CODES  = 12'h0f4;
  localparam logic [11:0] MSCAP_OFF_CTRL       = 12'h0e0;
  localparam logic [11:0] MSCAP_OFF_IRQ_STAT   = 12'h0e4;
  localparam logic [11:0] MSCAP_OFF_IRQ_MASK   = 12'h0e8;

  // ==========================================================================
  // constant field values
  // ==========================================================================
  localparam logic [7:0]  MSCAP_INT_CAP_CODE   = 8'h05;
  localparam logic [7:0]  MSCAP_BRD_CAP_CODE   = 8'h0d;
  localparam logic [7:0]  MSCAP_NEXT_LINK_RST  = 8'h00;
  localparam logic [2:0]  MSCAP_REQ_COUNT      = 3'h0;
  localparam logic [2:0]  MSCAP_GRANT_RST      = 3'h0;
  localparam logic        MSCAP_WIDE_CAPABLE   = 1'b1;
  localparam logic [31:0] MSCAP_ZERO32         = 32'h0000_0000;
  localparam logic [15:0] MSCAP_ZERO16         = 16'h0000;
  localparam logic [1:0]  MSCAP_ZERO2          = 2'h0;

  // ==========================================================================
  // status bit positions (events)
  // ==========================================================================
  localparam int          MSCAP_EVT_SENT       = 0;
  localparam int          MSCAP_EVT_DROPPED    = 1;
  localparam int          MSCAP_EVT_W          = 2;

  // ==========================================================================
  // message write sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    MSCAP_ST_IDLE = 3'b001,
    MSCAP_ST_REQ  = 3'b010,
    MSCAP_ST_DONE = 3'b100
  } mscap_state_e;

endpackage : mscap_pkg

// ==== mscap_cfg_if.sv ====
/*
  mscap_cfg_if: carries the programmed interrupt message settings from the
  register bank to the message write sequencer.
  Assumes: both ends in the same clock domain.
*/
`timescale 1ns/100ps

interface mscap_cfg_if;
  logic        msg_enable;    // interrupt message enable
  logic [29:0] addr_low;      // low address, dword bits
  logic [31:0] addr_high;     // upper address
  logic [15:0] payload;       // message data

  // register bank drives the settings
  modport bank (output msg_enable, output addr_low, output addr_high, output payload);
  // sequencer consumes them
  modport seq  (input msg_enable, input addr_low, input addr_high, input payload);
endinterface : mscap_cfg_if

// ==== mscap_msg_seq.sv ====
/*
  mscap_msg_seq: turns an interrupt request into one upstream memory write.
  Assumes: the upstream transmitter acknowledges with a one-cycle accept.
*/
`timescale 1ns/100ps

module mscap_msg_seq
  import mscap_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // settings
  mscap_cfg_if.seq         cfg,
  // request from the port
  input  wire logic        irq_req_i,
  // upstream write
  output logic             wr_valid_o,
  output logic             wr_wide_o,
  output logic [63:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  input  wire logic        wr_accept_i,
  // events
  output logic             sent_o,
  output logic             dropped_o
);

  mscap_state_e state_r;
  mscap_state_e state_nxt;
  logic         wide_w;
  logic         start_w;

  // address width choice and start condition
  assign wide_w  = (cfg.addr_high != MSCAP_ZERO32);         // [RULE8] [RULE9]
  assign start_w = irq_req_i && cfg.msg_enable;              // [RULE17]

  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MSCAP_ST_IDLE: if (start_w) state_nxt = MSCAP_ST_REQ;
      MSCAP_ST_REQ:  if (wr_accept_i) state_nxt = MSCAP_ST_DONE;
      MSCAP_ST_DONE: state_nxt = MSCAP_ST_IDLE;
      default:       state_nxt = MSCAP_ST_IDLE;
    endcase
  end

  // state and captured write, always sent upstream toward the root
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r    <= MSCAP_ST_IDLE;
      wr_valid_o <= 1'b0;
      wr_wide_o  <= 1'b0;
      wr_addr_o  <= 64'h0;
      wr_data_o  <= 32'h0;
      sent_o     <= 1'b0;
      dropped_o  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      sent_o    <= (state_r == MSCAP_ST_REQ) && wr_accept_i;
      dropped_o <= irq_req_i && !cfg.msg_enable;            // [RULE17]
      if ((state_r == MSCAP_ST_IDLE) && start_w)
      begin
        wr_valid_o <= 1'b1;                                  // [RULE10]
        wr_wide_o  <= wide_w;                                // [RULE8] [RULE9]
        wr_addr_o  <= wide_w ? {cfg.addr_high, cfg.addr_low, MSCAP_ZERO2}
                             : {MSCAP_ZERO32, cfg.addr_low, MSCAP_ZERO2};
        wr_data_o  <= {MSCAP_ZERO16, cfg.payload};           // [RULE12]
      end
      else if ((state_r == MSCAP_ST_REQ) && wr_accept_i)
        wr_valid_o <= 1'b0;
    end
  end

  // no write leaves while disabled at start
  property p_no_start_disabled;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_r == MSCAP_ST_IDLE && irq_req_i && !cfg.msg_enable) |=> !wr_valid_o;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("write started while disabled"); // [RULE17]

  // 32-bit form has zero upper address
  property p_narrow_addr;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_valid_o && !wr_wide_o) |-> (wr_addr_o[63:32] == MSCAP_ZERO32);
  endproperty
  a_narrow_addr: assert property (p_narrow_addr) else $error("narrow write has upper address"); // [RULE9]

  // wide form iff upper register non-zero at start
  property p_wide_pick;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_r == MSCAP_ST_IDLE && start_w) |=> (wr_wide_o == $past(wide_w) && wr_valid_o);
  endproperty
  a_wide_pick: assert property (p_wide_pick) else $error("address width choice wrong"); // [RULE8]

endmodule : mscap_msg_seq

// ==== mscap_upstream_model.sv ====
/*
  mscap_upstream_model: upstream transmitter toward the root that takes the
  interrupt memory writes of the port and acknowledges each one.
  Assumes: one clock; a write stands until its one-cycle accept.
*/
`timescale 1ns/100ps

module mscap_upstream_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // write from the port
  input  wire logic       wr_valid_i,
  input  wire logic [3:0] delay_i,
  output logic            wr_accept_o,
  output logic [7:0]      count_o
);
  // ==========================================================================
  // accept timing
  // ==========================================================================
  logic [3:0] wait_r;

  // every write is taken toward the root after delay_i stall cycles
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_r      <= 4'h0;
      wr_accept_o <= 1'b0;
      count_o     <= 8'h00;
    end
    else
    begin
      wr_accept_o <= 1'b0;
      if (wr_valid_i && !wr_accept_o)
      begin
        if (wait_r == delay_i)
        begin
          wr_accept_o <= 1'b1;
          wait_r      <= 4'h0;
          count_o     <= count_o + 8'h01;
        end
        else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // mscap_upstream_model

// ==== msi_and_subsystem_id_capability_tb.sv ====
/*
  msi_and_subsystem_id_capability_tb: self-checking bench of mscap_top.
  Assumes: APB slave with one wait state; upstream model acknowledges writes.
*/
`timescale 1ns/100ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end

module msi_and_subsystem_id_capability_tb;
  import mscap_pkg::*;

  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r0;
    logic [31:0] r1;
    logic        e;
  } mscap_row_s;

  // ==========================================================================
  // signals
  // ==========================================================================
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        irq_req_i = 1'b0;
  logic [3:0]  delay = 4'h0;
  logic [31:0] prdata_o, q;
  logic [63:0] wr_addr_o;
  logic [31:0] wr_data_o;
  logic [7:0]  count, c0;
  logic        pready_o, pslverr_o, wr_valid_o, wr_wide_o, wr_accept_i;
  logic        locked_o, irq_o, e;
  int          failures = 0;
  int          tests_run = 0;

  // write, then read back: reset value, value after write, error
  mscap_row_s rows [8] = '{
    '{12'h0d0, 32'hffff_ffff, 32'h0080_0005, 32'h00f1_ff05, 1'b0},
    '{12'h0d4, 32'hffff_ffff, 32'h0, 32'hffff_fffc, 1'b0},
    '{12'h0d8, 32'h1234_5678, 32'h0, 32'h1234_5678, 1'b0},
    '{12'h0dc, 32'hffff_abcd, 32'h0, 32'h0000_abcd, 1'b0},
    '{12'h0f0, 32'hffff_ffff, 32'h0000_000d, 32'h0000_ff0d, 1'b0},
    '{12'h0f4, 32'ha5a5_5a5a, 32'h0, 32'ha5a5_5a5a, 1'b0},
    '{12'h0e8, 32'hffff_ffff, 32'h0, 32'h0000_0003, 1'b0},
    '{12'h0fc, 32'h1, 32'h0, 32'h0, 1'b1}};

  // ==========================================================================
  // clock, design and partner
  // ==========================================================================
  always #10 clk_i = ~clk_i;

  mscap_top i_mscap_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_req_i(irq_req_i),
    .wr_valid_o(wr_valid_o), .wr_wide_o(wr_wide_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_accept_i(wr_accept_i), .locked_o(locked_o), .irq_o(irq_o));

  mscap_upstream_model i_mscap_upstream_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .wr_valid_i(wr_valid_o), .delay_i(delay), .wr_accept_o(wr_accept_i), .count_o(count));

  // ==========================================================================
  // tasks
  // ==========================================================================
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  // one interrupt request and the upstream write it gives
  task automatic fire(input logic [63:0] ea, input logic ew, input logic ev);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      irq_req_i <= 1'b1;
      @(posedge clk_i);
      irq_req_i <= 1'b0;
      while (wr_valid_o !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
      `CHK(wr_valid_o, ev)
      `CHK(wr_wide_o, ew)
      `CHK(wr_addr_o, ea)
      `CHK(wr_data_o, 32'h0000_abcd)
      while (wr_valid_o === 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    end
  endtask

  // verdict and end of run
  task automatic stop_test;
    begin
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ==========================================================================
  // watchdog
  // ==========================================================================
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // register table: reset value, write, read back
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(q, rows[i].r0)
      `CHK(e, rows[i].e)
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(q, rows[i].r1)
    end
    // address routed upstream, narrow then wide with a slow partner
    apb(1'b1, 12'h0d4, 32'h0000_1000);
    apb(1'b1, 12'h0d8, 32'h0);
    fire(64'h0000_0000_0000_1000, 1'b0, 1'b1);
    delay <= 4'h5;
    apb(1'b1, 12'h0d8, 32'h0000_0001);
    fire(64'h0000_0001_0000_1000, 1'b1, 1'b1);
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    apb(1'b0, 12'h0e4, 32'h0);
    `CHK(q, 32'h1)
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    // disabled: request dropped, nothing sent upstream
    apb(1'b1, 12'h0d0, 32'h0);
    c0 = count;
    // no write starts, so the last captured write must stay untouched
    fire(64'h0000_0001_0000_1000, 1'b1, 1'b0);
    `CHK(count, c0)
    apb(1'b0, 12'h0e4, 32'h0);
    `CHK(q, 32'h2)
    // locked: lockable fields keep their value
    apb(1'b1, 12'h0e0, 32'h1);
    // lock output trails the lock flop by one register stage
    repeat (2) @(posedge clk_i);
    `CHK(locked_o, 1'b1)
    apb(1'b1, 12'h0f4, 32'h0);
    apb(1'b0, 12'h0f4, 32'h0);
    `CHK(q, 32'ha5a5_5a5a)
    apb(1'b1, 12'h0f0, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(q, 32'h0000_ff0d)
    // second reset in mid-run
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    `CHK(locked_o, 1'b0)
    apb(1'b0, 12'h0d0, 32'h0);
    `CHK(q, 32'h0080_0005)
    apb(1'b0, 12'h0f4, 32'h0);
    `CHK(q, 32'h0)
    stop_test();
  end
endmodule // msi_and_subsystem_id_capability_tb
